// >>> rtl/insn_decode_defs.svh
// Constants for the instruction decoder and cycle sequencer
//
// Operation
// - Each instruction is one 14-bit word split into opcode and operand fields.
// - Every word falls into byte, bit, or literal/control class.
// - Byte ops: result-target bit 0 writes accumulator, 1 writes the file register.
// - Register field addresses 0x00..0x7F inside the selected data bank.
// - Bit ops: position field selects one bit of the 8-bit register.
// - Literal ops take an 8-bit or 11-bit constant depending on instruction.
// - One instruction cycle is exactly four oscillator periods.
// - True tests and PC changes take two cycles, the second a no-op.
// - Instructions naming a register read, modify, then store the result.
// - The addressed register is read even by write-only instructions like clear.
// - Read-modify-write on the port register counts as a port read.
// - Don't-care instruction bits never change how a word decodes.
// - Interrupt service clears global enable, pushes return address, jumps to vector.
`ifndef INSN_DECODE_DEFS_SVH
`define INSN_DECODE_DEFS_SVH

`define INSN_W 14
`define PC_W 13
`define OSC_PER_CYC 4
`define IRQ_VECTOR 13'h0004
`define PORT_ADDR 9'h006
`define STK_DEPTH 8

// Field positions inside the instruction word
`define CLS_HI 13
`define CLS_LO 12
`define BOP_HI 11
`define BOP_LO 8
`define DEST_BIT 7
`define FADR_HI 6
`define BPOS_HI 9
`define BPOS_LO 7
`define K8_HI 7
`define K11_HI 10

// Reset values
`define PC_RST 13'h0000
`define W_RST 8'h00
`define INSN_RST 14'h0000

`endif

// >>> rtl/insn_decode_pkg.sv
// Types shared by the decoder and the sequencer
package insn_decode_pkg;

   typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LIT} insn_cls_t;

   typedef enum logic [4:0] {
      OP_NOP, OP_MOVWF, OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR, OP_ADD,
      OP_MOV, OP_COM, OP_INC, OP_DECSZ, OP_RR, OP_RL, OP_SWAP, OP_INCSZ,
      OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS, OP_MOVLW, OP_RETLW,
      OP_CALL, OP_GOTO, OP_RETURN, OP_RETFIE
   } insn_op_t;

   typedef struct packed {
      insn_cls_t cls;
      insn_op_t op;
      logic uses_file;
      logic wr_file;
      logic wr_acc;
      logic dest;
      logic [6:0] fadr;
      logic [2:0] bpos;
      logic [7:0] k8;
      logic [10:0] k11;
   } insn_fields_t;

endpackage

// >>> rtl/insn_field_split.sv
// Combinational split of an instruction word into class, operation and fields
`timescale 1ns/1ns
`include "insn_decode_defs.svh"

module insn_field_split
   import insn_decode_pkg::*;
(
   input wire logic [`INSN_W-1:0] insn_in,
   output insn_fields_t fl_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Field extraction and opcode match; wildcards cover the don't-care bits
   always_comb begin
      fl_out = '0;
      fl_out.dest = insn_in[`DEST_BIT];
      fl_out.fadr = insn_in[`FADR_HI:0];
      fl_out.bpos = insn_in[`BPOS_HI:`BPOS_LO];
      fl_out.k8 = insn_in[`K8_HI:0];
      fl_out.k11 = insn_in[`K11_HI:0];
      unique case (insn_in[`CLS_HI:`CLS_LO])
         2'h0: fl_out.cls = CLS_BYTE;
         2'h1: fl_out.cls = CLS_BIT;
         default: fl_out.cls = CLS_LIT;
      endcase
      // Priority order matters: control words sit inside the byte space
      casez (insn_in)
         14'b00_0000_0000_1000: fl_out.op = OP_RETURN;
         14'b00_0000_0000_1001: fl_out.op = OP_RETFIE;
         14'b00_0000_1???_????: begin
            fl_out.op = OP_MOVWF;
            fl_out.uses_file = 1'b1;
            fl_out.wr_file = 1'b1;
         end
         14'b00_0000_0???_????: fl_out.op = OP_NOP;
         14'b00_0001_0???_????: begin
            fl_out.op = OP_CLR;
            fl_out.wr_acc = 1'b1;
         end
         14'b00_????_????_????: begin
            fl_out.uses_file = 1'b1;
            fl_out.wr_file = insn_in[`DEST_BIT];
            fl_out.wr_acc = !insn_in[`DEST_BIT];
            unique case (insn_in[`BOP_HI:`BOP_LO])
               4'h1: fl_out.op = OP_CLR;
               4'h2: fl_out.op = OP_SUB;
               4'h3: fl_out.op = OP_DEC;
               4'h4: fl_out.op = OP_IOR;
               4'h5: fl_out.op = OP_AND;
               4'h6: fl_out.op = OP_XOR;
               4'h7: fl_out.op = OP_ADD;
               4'h8: fl_out.op = OP_MOV;
               4'h9: fl_out.op = OP_COM;
               4'hA: fl_out.op = OP_INC;
               4'hB: fl_out.op = OP_DECSZ;
               4'hC: fl_out.op = OP_RR;
               4'hD: fl_out.op = OP_RL;
               4'hE: fl_out.op = OP_SWAP;
               4'hF: fl_out.op = OP_INCSZ;
               default: fl_out.op = OP_NOP;
            endcase
         end
         14'b01_????_????_????: begin
            fl_out.uses_file = 1'b1;
            fl_out.op = insn_op_t'(5'(OP_BCF) + 5'(insn_in[11:10]));
            fl_out.wr_file = !insn_in[11];
         end
         14'b10_0???_????_????: fl_out.op = OP_CALL;
         14'b10_1???_????_????: fl_out.op = OP_GOTO;
         14'b11_00??_????_????: begin
            fl_out.op = OP_MOVLW;
            fl_out.wr_acc = 1'b1;
         end
         14'b11_01??_????_????: begin
            fl_out.op = OP_RETLW;
            fl_out.wr_acc = 1'b1;
         end
         14'b11_1000_????_????, 14'b11_1001_????_????, 14'b11_1010_????_????,
         14'b11_110?_????_????, 14'b11_111?_????_????: begin
            fl_out.wr_acc = 1'b1;
            unique casez (insn_in[11:8])
               4'b1000: fl_out.op = OP_IOR;
               4'b1001: fl_out.op = OP_AND;
               4'b1010: fl_out.op = OP_XOR;
               4'b110?: fl_out.op = OP_SUB;
               default: fl_out.op = OP_ADD;
            endcase
         end
         default: fl_out.op = OP_NOP;
      endcase
   end

endmodule

// >>> rtl/byte_bit_literal_insn_decode.sv
// Instruction sequencer: four-phase cycle, read-modify-write datapath, PC and stack
`timescale 1ns/1ns
`include "insn_decode_defs.svh"

module byte_bit_literal_insn_decode
   import insn_decode_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [`INSN_W-1:0] insn_in,
   input wire logic [1:0] bank_in,
   input wire logic [7:0] rf_rdata_in,
   input wire logic irq_in,
   output logic [`PC_W-1:0] pm_addr_out,
   output logic [8:0] rf_addr_out,
   output logic rf_rd_out,
   output logic rf_wr_out,
   output logic [7:0] rf_wdata_out,
   output logic port_read_out,
   output logic [7:0] acc_out,
   output logic zero_out,
   output logic carry_out,
   output logic global_interrupt_enable_out,
   output logic cyc_strobe_out
);

   insn_fields_t fl;
   logic [1:0] q_r, q_nxt;
   logic [`INSN_W-1:0] insn_r, insn_nxt;
   logic flush_r, flush_nxt, skip_r, skip_nxt;
   logic [`PC_W-1:0] pc_r, pc_nxt;
   logic [`PC_W-1:0] stk_r [`STK_DEPTH], stk_nxt [`STK_DEPTH];
   logic [2:0] sp_r, sp_nxt;
   logic [7:0] w_r, w_nxt, opnd_r, opnd_nxt, res_r, res_nxt;
   logic c_r, c_nxt, z_r, z_nxt, int_en_r, int_en_nxt;
   logic wr_w_r, wr_w_nxt, rf_rd_r, rf_rd_nxt, rf_wr_r, rf_wr_nxt;
   logic port_rd_r, port_rd_nxt, cyc_r, cyc_nxt;
   logic [8:0] rf_addr_r, rf_addr_nxt;
   logic [8:0] sum;
   logic [7:0] a;
   logic take;

   ////////////////////////////////////////////////////////////////////////////
   // Field split of the word being executed
   insn_field_split u_split (
      .insn_in(insn_r),
      .fl_out(fl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic, one phase of the instruction cycle per clock
   always_comb begin
      q_nxt = q_r + 2'h1;
      insn_nxt = insn_r;
      flush_nxt = flush_r;
      skip_nxt = skip_r;
      pc_nxt = pc_r;
      stk_nxt = stk_r;
      sp_nxt = sp_r;
      w_nxt = w_r;
      opnd_nxt = opnd_r;
      res_nxt = res_r;
      c_nxt = c_r;
      z_nxt = z_r;
      int_en_nxt = int_en_r;
      wr_w_nxt = wr_w_r;
      rf_addr_nxt = rf_addr_r;
      rf_rd_nxt = 1'b0;
      rf_wr_nxt = 1'b0;
      port_rd_nxt = 1'b0;
      cyc_nxt = 1'b0;
      take = 1'b0;
      sum = 9'h000;
      a = fl.uses_file ? opnd_r : fl.k8;
      unique case (q_r)
         2'h0: begin
            // Every register-naming instruction reads, even clear and move-to
            rf_addr_nxt = {bank_in, fl.fadr};
            if (!flush_r && fl.uses_file) begin
               rf_rd_nxt = 1'b1;
               port_rd_nxt = ({bank_in, fl.fadr} == `PORT_ADDR);
            end
         end
         2'h1: begin
            opnd_nxt = rf_rdata_in;
         end
         2'h2: begin
            // Modify step; the flushed second cycle stores nothing
            res_nxt = a;
            skip_nxt = 1'b0;
            wr_w_nxt = fl.wr_acc && !flush_r;
            rf_wr_nxt = fl.wr_file && !flush_r;
            if (!flush_r) begin
               unique case (fl.op)
                  OP_MOVWF: res_nxt = w_r;
                  OP_CLR: res_nxt = 8'h00;
                  OP_SUB: begin
                     sum = {1'b0, a} + {1'b0, ~w_r} + 9'h001;
                     res_nxt = sum[7:0];
                     c_nxt = sum[8];
                  end
                  OP_ADD: begin
                     sum = {1'b0, a} + {1'b0, w_r};
                     res_nxt = sum[7:0];
                     c_nxt = sum[8];
                  end
                  OP_DEC, OP_DECSZ: res_nxt = a - 8'h01;
                  OP_INC, OP_INCSZ: res_nxt = a + 8'h01;
                  OP_IOR: res_nxt = a | w_r;
                  OP_AND: res_nxt = a & w_r;
                  OP_XOR: res_nxt = a ^ w_r;
                  OP_COM: res_nxt = ~a;
                  OP_RR: begin
                     res_nxt = {c_r, a[7:1]};
                     c_nxt = a[0];
                  end
                  OP_RL: begin
                     res_nxt = {a[6:0], c_r};
                     c_nxt = a[7];
                  end
                  OP_SWAP: res_nxt = {a[3:0], a[7:4]};
                  OP_BCF: res_nxt = a & ~(8'h01 << fl.bpos);
                  OP_BSF: res_nxt = a | (8'h01 << fl.bpos);
                  OP_BTFSC: skip_nxt = !a[fl.bpos];
                  OP_BTFSS: skip_nxt = a[fl.bpos];
                  OP_MOVLW, OP_RETLW: res_nxt = fl.k8;
                  default: res_nxt = a;
               endcase
               if (fl.op inside {OP_DECSZ, OP_INCSZ}) begin
                  skip_nxt = (res_nxt == 8'h00);
               end
               if (fl.op inside {OP_CLR, OP_SUB, OP_ADD, OP_DEC, OP_INC, OP_IOR, OP_AND,
                                 OP_XOR, OP_MOV, OP_COM}) begin
                  z_nxt = (res_nxt == 8'h00);
               end
            end
         end
         2'h3: begin
            // Commit, then fetch; pc_r already names the word being fetched
            cyc_nxt = 1'b1;
            insn_nxt = insn_in;
            pc_nxt = pc_r + 13'h0001;
            flush_nxt = skip_r;
            if (wr_w_r) begin
               w_nxt = res_r;
            end
            if (!flush_r) begin
               unique case (fl.op)
                  OP_CALL, OP_GOTO: begin
                     if (fl.op == OP_CALL) begin
                        stk_nxt[sp_r] = pc_r;
                        sp_nxt = sp_r + 3'h1;
                     end
                     pc_nxt = {pc_r[12:11], fl.k11};
                     flush_nxt = 1'b1;
                  end
                  OP_RETURN, OP_RETLW, OP_RETFIE: begin
                     sp_nxt = sp_r - 3'h1;
                     pc_nxt = stk_r[sp_nxt];
                     flush_nxt = 1'b1;
                     if (fl.op == OP_RETFIE) begin
                        int_en_nxt = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            // Never interrupt in front of a word that is about to be dropped
            if (irq_in && int_en_r && !flush_nxt) begin
               take = 1'b1;
               stk_nxt[sp_r] = pc_r;
               sp_nxt = sp_r + 3'h1;
               pc_nxt = `IRQ_VECTOR;
               int_en_nxt = 1'b0;
               flush_nxt = 1'b1;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers; first cycle after reset runs as a no-op
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         q_r <= 2'h0;
         insn_r <= `INSN_RST;
         flush_r <= 1'b1;
         skip_r <= 1'b0;
         pc_r <= `PC_RST;
         for (int i = 0; i < `STK_DEPTH; i++) begin
            stk_r[i] <= `PC_RST;
         end
         sp_r <= 3'h0;
         w_r <= `W_RST;
         opnd_r <= 8'h00;
         res_r <= 8'h00;
         c_r <= 1'b0;
         z_r <= 1'b0;
         int_en_r <= 1'b0;
         wr_w_r <= 1'b0;
         rf_addr_r <= 9'h000;
         rf_rd_r <= 1'b0;
         rf_wr_r <= 1'b0;
         port_rd_r <= 1'b0;
         cyc_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
         insn_r <= insn_nxt;
         flush_r <= flush_nxt;
         skip_r <= skip_nxt;
         pc_r <= pc_nxt;
         stk_r <= stk_nxt;
         sp_r <= sp_nxt;
         w_r <= w_nxt;
         opnd_r <= opnd_nxt;
         res_r <= res_nxt;
         c_r <= c_nxt;
         z_r <= z_nxt;
         int_en_r <= int_en_nxt;
         wr_w_r <= wr_w_nxt;
         rf_addr_r <= rf_addr_nxt;
         rf_rd_r <= rf_rd_nxt;
         rf_wr_r <= rf_wr_nxt;
         port_rd_r <= port_rd_nxt;
         cyc_r <= cyc_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops
   assign pm_addr_out = pc_r;
   assign rf_addr_out = rf_addr_r;
   assign rf_rd_out = rf_rd_r;
   assign rf_wr_out = rf_wr_r;
   assign rf_wdata_out = res_r;
   assign port_read_out = port_rd_r;
   assign acc_out = w_r;
   assign zero_out = z_r;
   assign carry_out = c_r;
   assign global_interrupt_enable_out = int_en_r;
   assign cyc_strobe_out = cyc_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   cycle_four_a: assert property (cyc_r |=> !cyc_r [*3] ##1 cyc_r)
      else $error("instruction cycle is not four clocks");
   fetch_split_a: assert property (cyc_r |-> insn_r == $past(insn_in))
      else $error("instruction word not taken at cycle end");
   dest_acc_a: assert property (rf_wr_r && fl.cls == CLS_BYTE |-> fl.dest)
      else $error("byte op wrote the register with target bit clear");
   bank_addr_a: assert property (rf_rd_r |-> rf_addr_r == {$past(bank_in), fl.fadr})
      else $error("register address not bank plus field");
   bit_set_a: assert property (rf_wr_r && fl.op == OP_BSF |-> res_r[fl.bpos])
      else $error("bit set did not set the selected bit");
   goto_k11_a: assert property (q_r == 2'h3 && !flush_r && fl.op == OP_GOTO && !take
                                |=> pc_r[10:0] == $past(fl.k11))
      else $error("jump target not taken from 11-bit field");
   branch_nop_a: assert property (q_r == 2'h3 && !flush_r && fl.op inside {OP_CALL, OP_GOTO}
                                  |=> flush_r ##1 !rf_rd_r [*3])
      else $error("branch not followed by a no-op cycle");
   clear_reads_a: assert property (q_r == 2'h0 && !flush_r && fl.op == OP_CLR && fl.dest
                                   |=> rf_rd_r ##2 rf_wr_r && res_r == 8'h00)
      else $error("clear did not read then write zero");
   port_touch_a: assert property (rf_rd_r |-> port_rd_r == (rf_addr_r == `PORT_ADDR))
      else $error("port read flag wrong");
   dontcare_a: assert property (insn_r[13:10] == 4'hC |-> fl.op == OP_MOVLW)
      else $error("don't-care bits changed decode");
   irq_entry_a: assert property (q_r == 2'h3 && take
                                 |=> pc_r == `IRQ_VECTOR && !int_en_r && flush_r)
      else $error("interrupt entry wrong");

   irq_taken_c: cover property (q_r == 2'h3 && take);
   skip_taken_c: cover property (q_r == 2'h3 && skip_r);
   port_rmw_c: cover property (port_rd_r ##2 rf_wr_r);

endmodule

// >>> verification/fetch_regfile_model.sv
// Behavioural program memory and data register file facing the sequencer
`timescale 1ns/1ns
`include "insn_decode_defs.svh"

module fetch_regfile_model (
   input wire logic sys_clk_in,
   input wire logic [`PC_W-1:0] pm_addr_in,
   input wire logic [8:0] rf_addr_in,
   input wire logic rf_rd_in,
   input wire logic rf_wr_in,
   input wire logic [7:0] rf_wdata_in,
   output logic [`INSN_W-1:0] insn_out,
   output logic [7:0] rf_rdata_out
);
   logic [`INSN_W-1:0] prog [0:255];
   logic [7:0] mem [0:511];
   logic [7:0] last_r = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Program words come straight from the array; only the low address bits decode
   assign insn_out = prog[pm_addr_in[7:0]];
   // Outside a read the data lines show the inverse of the last value, so a late
   // capture by the sequencer cannot pass by luck
   assign rf_rdata_out = rf_rd_in ? mem[rf_addr_in] : ~last_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Register file store; a plain always so the bench may preset cells
   always @(posedge sys_clk_in) begin
      if (rf_rd_in) begin
         last_r <= mem[rf_addr_in];
      end
      if (rf_wr_in) begin
         mem[rf_addr_in] <= rf_wdata_in;
      end
   end
endmodule

// >>> verification/byte_bit_literal_insn_decode_tb.sv
// Self-checking bench for the instruction decoder and cycle sequencer
`timescale 1ns/1ns
`include "insn_decode_defs.svh"

module byte_bit_literal_insn_decode_tb;
   typedef struct packed {
      logic [7:0] w;
      logic [1:0] bank;
      logic [13:0] insn;
      logic [7:0] pre;
      logic [7:0] acc;
      logic [7:0] mem;
      logic [3:0] flags; // zero, carry, skipped, names a file register
   } row_t;

   logic sys_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic irq_in = 1'b0;
   logic [1:0] bank_in = 2'h0;
   logic [13:0] insn;
   logic [7:0] rf_rdata;
   logic [12:0] pm_addr_out;
   logic [8:0] rf_addr_out;
   logic rf_rd_out, rf_wr_out, port_read_out, zero_out, carry_out, int_en, cyc_strobe_out;
   logic [7:0] rf_wdata_out, acc_out;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int rd_cnt, pr_cnt, wr_n;
   int wr_t [4];
   logic [8:0] wr_a [4];
   row_t rows [25];
   row_t r;
   logic seen_int_en;

   byte_bit_literal_insn_decode u_byte_bit_literal_insn_decode (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in), .insn_in(insn), .bank_in(bank_in),
      .rf_rdata_in(rf_rdata), .irq_in(irq_in), .pm_addr_out(pm_addr_out),
      .rf_addr_out(rf_addr_out), .rf_rd_out(rf_rd_out), .rf_wr_out(rf_wr_out),
      .rf_wdata_out(rf_wdata_out), .port_read_out(port_read_out), .acc_out(acc_out),
      .zero_out(zero_out), .carry_out(carry_out), .global_interrupt_enable_out(int_en),
      .cyc_strobe_out(cyc_strobe_out));

   fetch_regfile_model u_fetch_regfile_model (
      .sys_clk_in(sys_clk_in), .pm_addr_in(pm_addr_out), .rf_addr_in(rf_addr_out),
      .rf_rd_in(rf_rd_out), .rf_wr_in(rf_wr_out), .rf_wdata_in(rf_wdata_out),
      .insn_out(insn), .rf_rdata_out(rf_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      forever #20 sys_clk_in = ~sys_clk_in;
   end

   // Bus activity counters, cleared while reset is held; also cuts a hang short
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (srst_in) begin
         rd_cnt <= 0;
         pr_cnt <= 0;
         wr_n <= 0;
      end else begin
         if (rf_rd_out) rd_cnt <= rd_cnt + 1;
         if (port_read_out) pr_cnt <= pr_cnt + 1;
         if (rf_wr_out && wr_n < 4) begin
            wr_t[wr_n] <= cycles;
            wr_a[wr_n] <= rf_addr_out;
            wr_n <= wr_n + 1;
         end
      end
      if (cycles == 5000) begin
         fail_count = fail_count + 1;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Programs are loaded while reset is held, so nothing half-loaded ever runs
   task rst_on(input logic [1:0] b);
      int a;
      @(posedge sys_clk_in);
      srst_in <= 1'b1;
      bank_in <= b;
      @(posedge sys_clk_in);
      for (a = 0; a < 256; a++) u_fetch_regfile_model.prog[a] = 14'h0000;
   endtask

   task go(input int n);
      repeat (10) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task ld(input int a, input logic [13:0] w);
      u_fetch_regfile_model.prog[a] = w;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      // One row per operation: load W, run it, then store W to 0x70 unless skipped
      rows = '{
         '{8'h22, 2'h1, 14'h07A0, 8'h10, 8'h22, 8'h32, 4'h1},
         '{8'h22, 2'h1, 14'h0720, 8'h10, 8'h32, 8'h10, 4'h1},
         '{8'h22, 2'h1, 14'h01A0, 8'h5A, 8'h22, 8'h00, 4'h9},
         '{8'h10, 2'h1, 14'h0220, 8'h10, 8'h00, 8'h10, 4'hD},
         '{8'h22, 2'h1, 14'h0320, 8'h01, 8'h00, 8'h01, 4'h9},
         '{8'hF0, 2'h1, 14'h04A0, 8'h0F, 8'hF0, 8'hFF, 4'h1},
         '{8'h3C, 2'h1, 14'h05A0, 8'hF0, 8'h3C, 8'h30, 4'h1},
         '{8'h0F, 2'h1, 14'h0620, 8'hFF, 8'hF0, 8'hFF, 4'h1},
         '{8'h22, 2'h1, 14'h0820, 8'h00, 8'h00, 8'h00, 4'h9},
         '{8'h22, 2'h1, 14'h09A0, 8'h0F, 8'h22, 8'hF0, 4'h1},
         '{8'h22, 2'h0, 14'h0A86, 8'hFF, 8'h22, 8'h00, 4'h9},
         '{8'h22, 2'h1, 14'h0BA0, 8'h01, 8'h22, 8'h00, 4'h3},
         '{8'h22, 2'h1, 14'h0C20, 8'h81, 8'h40, 8'h81, 4'h5},
         '{8'h22, 2'h1, 14'h0DA0, 8'h81, 8'h22, 8'h02, 4'h5},
         '{8'h22, 2'h1, 14'h0E20, 8'h12, 8'h21, 8'h12, 4'h1},
         '{8'h22, 2'h1, 14'h0FA0, 8'h05, 8'h22, 8'h06, 4'h1},
         '{8'h22, 2'h2, 14'h1020, 8'hFF, 8'h22, 8'hFE, 4'h1},
         '{8'h22, 2'h3, 14'h17A0, 8'h00, 8'h22, 8'h80, 4'h1},
         '{8'h22, 2'h1, 14'h19A0, 8'h00, 8'h22, 8'h00, 4'h3},
         '{8'h22, 2'h1, 14'h1DA0, 8'h00, 8'h22, 8'h00, 4'h1},
         '{8'h22, 2'h1, 14'h33C4, 8'h00, 8'hC4, 8'h00, 4'h0},
         '{8'h22, 2'h1, 14'h0000, 8'h00, 8'h22, 8'h00, 4'h0},
         '{8'h22, 2'h1, 14'h0060, 8'h00, 8'h22, 8'h00, 4'h0},
         '{8'h22, 2'h1, 14'h3C22, 8'h00, 8'h00, 8'h00, 4'hC},
         '{8'h22, 2'h1, 14'h3E05, 8'h00, 8'h27, 8'h00, 4'h0}};
      foreach (rows[i]) begin
         r = rows[i];
         rst_on(r.bank);
         ld(0, {6'h30, r.w});
         ld(1, r.insn);
         ld(2, 14'h00F0);
         ld(3, 14'h2803);
         u_fetch_regfile_model.mem[{r.bank, r.insn[6:0]}] = r.pre;
         u_fetch_regfile_model.mem[{r.bank, 7'h70}] = 8'hEE;
         go(48);
         check("acc", acc_out, r.acc);
         check("file", u_fetch_regfile_model.mem[{r.bank, r.insn[6:0]}], r.mem);
         check("store", u_fetch_regfile_model.mem[{r.bank, 7'h70}],
               r.flags[1] ? 8'hEE : r.acc);
         check("status", {zero_out, carry_out}, r.flags[3:2]);
         check("reads", rd_cnt, 16'(r.flags[0]) + 16'(!r.flags[1]));
         check("port reads", pr_cnt,
               16'(r.flags[0] && {r.bank, r.insn[6:0]} == 9'h006));
      end
      // Reset values, then the strobe every fourth clock after release
      rst_on(2'h0);
      repeat (10) @(posedge sys_clk_in);
      #1;
      check("reset pc acc", {pm_addr_out[7:0], acc_out}, 16'h0000);
      check("reset ctl", {int_en, cyc_strobe_out, rf_rd_out, rf_wr_out}, 16'h0000);
      @(posedge sys_clk_in);
      srst_in <= 1'b0;
      for (int k = 1; k <= 13; k++) begin
         @(posedge sys_clk_in);
         #1;
         check("strobe", cyc_strobe_out, 16'(k % 4 == 0));
      end
      // Stores around a jump and a call/return: the jump, the call and the return each add one dead cycle
      rst_on(2'h0);
      ld(0, 14'h00F1);
      ld(1, 14'h2802);
      ld(2, 14'h00F2);
      ld(3, 14'h2006);
      ld(4, 14'h00F3);
      ld(5, 14'h2805);
      ld(6, 14'h0008);
      go(80);
      check("writes", wr_n, 16'h0003);
      for (int k = 0; k < 3; k++) check("write addr", wr_a[k], 16'h0071 + k);
      check("jump gap", wr_t[1] - wr_t[0], 16'h000C);
      check("call gap", wr_t[2] - wr_t[1], 16'h0014);
      // Return-from-interrupt enables, then a pending request vectors the core
      rst_on(2'h0);
      irq_in <= 1'b1;
      ld(0, 14'h2002);
      ld(1, 14'h2801);
      ld(2, 14'h0009);
      ld(3, 14'h2803);
      ld(4, 14'h00F4);
      ld(5, 14'h2805);
      u_fetch_regfile_model.mem[9'h074] = 8'hEE;
      seen_int_en = 1'b0;
      go(0);
      for (int k = 0; k < 80 && pm_addr_out !== 13'h0004; k++) begin
         @(posedge sys_clk_in);
         #1;
         if (int_en === 1'b1) seen_int_en = 1'b1;
      end
      check("enable seen", seen_int_en, 16'h0001);
      check("vector", pm_addr_out, 16'h0004);
      check("enable cleared", int_en, 16'h0000);
      @(posedge sys_clk_in);
      irq_in <= 1'b0;
      repeat (24) @(posedge sys_clk_in);
      #1;
      check("handler store", u_fetch_regfile_model.mem[9'h074], 16'h0000);
      summarize();
   end
endmodule
